// [logic/pmtac_ctrl.v]
// nonvolatile access control, unlock, table latch and table pointer logic
`include "pmtac_defs.vh"
`default_nettype none
module pmtac_ctrl #(
	parameter [19:0] LONG_WRITE_CYCLES = 20'd80000
) (
	input wire clk_i,
	input wire reset_i,
	input wire abort_reset_i,
	input wire [11:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	input wire sfr_write_i,
	input wire sfr_read_i,
	output reg [7:0] sfr_rdata_o,
	input wire tbl_read_i,
	input wire tbl_write_i,
	input wire [1:0] tbl_mode_i,
	output wire tbl_busy_o,
	output reg [21:0] mem_addr_o,
	input wire [7:0] mem_rdata_i,
	output reg mem_read_o,
	output reg hold_write_o,
	output reg [2:0] hold_index_o,
	output reg [7:0] hold_data_o,
	output reg nv_start_o,
	output reg nv_erase_o,
	output reg [1:0] nv_space_o,
	output reg [18:0] nv_block_o,
	output reg ee_read_o,
	output wire cpu_stall_o,
	output reg nv_write_done_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_KEY1 = 2'h1;
	localparam [1:0] ST_ARMED = 2'h2;
	localparam [1:0] ST_WRITE = 2'h3;
	localparam [1:0] SP_EEPROM = 2'h0;
	localparam [1:0] SP_FLASH = 2'h1;
	localparam [1:0] SP_CONFIG = 2'h2;
	reg [1:0] state;
	reg [1:0] next_state;
	reg target_sel;
	reg cfg_sel;
	reg erase_en;
	reg error_flag;
	reg wr_en;
	reg wr_strobe;
	reg rd_strobe;
	reg [7:0] latch;
	reg [21:0] pointer;
	reg tbl_pending;
	reg tbl_is_write;
	reg [1:0] tbl_mode_q;
	reg [2:0] abort_sync;
	reg abort_level;
	reg timer_start;
	reg [19:0] timer_len;
	wire timer_busy;
	wire timer_done;
	wire [7:0] ctrl_value;
	wire start_ok;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// address decode reused by read and write paths
	function hit;
		input [11:0] a;
		input [11:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// space selection: config overrides target
	function [1:0] space_of;
		input t;
		input c;
		begin
			if (c) begin
				space_of = SP_CONFIG;
			end else if (t) begin
				space_of = SP_FLASH;
			end else begin
				space_of = SP_EEPROM;
			end
		end
	endfunction

	// pointer step confined to the low 21 bits
	function [21:0] step;
		input [21:0] p;
		input dn;
		begin
			if (dn) begin
				step = {p[21], p[20:0] - 21'h000001};
			end else begin
				step = {p[21], p[20:0] + 21'h000001};
			end
		end
	endfunction

	// ****************************************************************
	// control register image
	// ****************************************************************
	assign ctrl_value = {target_sel, cfg_sel, 1'b0, erase_en, error_flag, wr_en, wr_strobe, rd_strobe};
	assign start_ok = sfr_write_i && hit(sfr_addr_i, `PMTAC_ADDR_CTRL) && sfr_wdata_i[`PMTAC_BIT_WSTROBE]
		&& !wr_strobe && !timer_busy && wr_en && state == ST_ARMED;
	assign cpu_stall_o = wr_strobe && (target_sel || cfg_sel) || tbl_pending;
	assign tbl_busy_o = tbl_pending;

	// three-stage sync of the abort reset request
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			abort_sync <= 3'h0;
			abort_level <= 1'b0;
		end else begin
			abort_sync <= {abort_sync[1:0], abort_reset_i};
			if (abort_sync[2] == abort_sync[1]) begin
				abort_level <= abort_sync[2];
			end
		end
	end

	// unlock sequence watcher
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (sfr_write_i && hit(sfr_addr_i, `PMTAC_ADDR_UNLOCK) && sfr_wdata_i == `PMTAC_KEY_FIRST) begin
					next_state = ST_KEY1;
				end
			end
			ST_KEY1: begin
				if (sfr_write_i) begin
					if (hit(sfr_addr_i, `PMTAC_ADDR_UNLOCK) && sfr_wdata_i == `PMTAC_KEY_SECOND) begin
						next_state = ST_ARMED;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_ARMED: begin
				if (start_ok) begin
					next_state = ST_WRITE;
				end else if (sfr_write_i) begin
					next_state = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (timer_done || abort_level) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// timer launch and length select
	always @* begin
		timer_start = start_ok;
		if (target_sel || cfg_sel) begin
			timer_len = LONG_WRITE_CYCLES;
		end else begin
			timer_len = `PMTAC_EE_WRITE_CYCLES;
		end
	end

	pmtac_write_timer #(
		.LONG_CYCLES(LONG_WRITE_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.reset_i(reset_i | abort_level),
		.start_i(timer_start),
		.length_i(timer_len),
		.busy_o(timer_busy),
		.done_o(timer_done)
	);

	// ****************************************************************
	// control register and sequencing
	// ****************************************************************
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			target_sel <= 1'b0;
			cfg_sel <= 1'b0;
			erase_en <= 1'b0;
			error_flag <= 1'b0;
			wr_en <= 1'b0;
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
			nv_start_o <= 1'b0;
			nv_erase_o <= 1'b0;
			nv_space_o <= SP_EEPROM;
			nv_block_o <= 19'h00000;
			ee_read_o <= 1'b0;
			nv_write_done_o <= 1'b0;
		end else begin
			state <= next_state;
			nv_start_o <= 1'b0;
			ee_read_o <= 1'b0;
			nv_write_done_o <= 1'b0;
			rd_strobe <= 1'b0;
			if (sfr_write_i && hit(sfr_addr_i, `PMTAC_ADDR_CTRL)) begin
				target_sel <= sfr_wdata_i[`PMTAC_BIT_TARGET];
				cfg_sel <= sfr_wdata_i[`PMTAC_BIT_CFGSEL];
				erase_en <= sfr_wdata_i[`PMTAC_BIT_ERASE];
				error_flag <= sfr_wdata_i[`PMTAC_BIT_ERROR];
				wr_en <= sfr_wdata_i[`PMTAC_BIT_WRITE_ENABLE_BIT];
				if (sfr_wdata_i[`PMTAC_BIT_RSTROBE] && !sfr_wdata_i[`PMTAC_BIT_TARGET] && !wr_strobe) begin
					rd_strobe <= 1'b1;
					ee_read_o <= 1'b1;
				end
			end
			if (start_ok) begin
				wr_strobe <= 1'b1;
				nv_start_o <= 1'b1;
				nv_erase_o <= erase_en;
				nv_space_o <= space_of(target_sel, cfg_sel);
				if (erase_en) begin
					nv_block_o <= {pointer[21:6], 3'h0};
				end else begin
					nv_block_o <= pointer[21:3];
				end
			end
			if (state == ST_WRITE && abort_level) begin
				wr_strobe <= 1'b0;
				error_flag <= 1'b1; // select bits untouched
			end else if (state == ST_WRITE && timer_done) begin
				wr_strobe <= 1'b0;
				erase_en <= 1'b0;
				error_flag <= 1'b0;
				nv_write_done_o <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// table latch, pointer and table instructions
	// ****************************************************************
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			latch <= 8'h00;
			pointer <= 22'h000000;
			tbl_pending <= 1'b0;
			tbl_is_write <= 1'b0;
			tbl_mode_q <= `PMTAC_MODE_KEEP;
			mem_addr_o <= 22'h000000;
			mem_read_o <= 1'b0;
			hold_write_o <= 1'b0;
			hold_index_o <= 3'h0;
			hold_data_o <= 8'h00;
		end else begin
			mem_read_o <= 1'b0;
			hold_write_o <= 1'b0;
			if (sfr_write_i && hit(sfr_addr_i, `PMTAC_ADDR_LATCH)) begin
				latch <= sfr_wdata_i;
			end
			if (sfr_write_i && hit(sfr_addr_i, `PMTAC_ADDR_PTR_LOW)) begin
				pointer[7:0] <= sfr_wdata_i;
			end
			if (sfr_write_i && hit(sfr_addr_i, `PMTAC_ADDR_PTR_HIGH)) begin
				pointer[15:8] <= sfr_wdata_i;
			end
			if (sfr_write_i && hit(sfr_addr_i, `PMTAC_ADDR_PTR_UPPER)) begin
				pointer[21:16] <= sfr_wdata_i[5:0];
			end
			if ((tbl_read_i || tbl_write_i) && !cpu_stall_o) begin // long writes and a pending table op hold off table work
				tbl_pending <= 1'b1;
				tbl_is_write <= tbl_write_i;
				tbl_mode_q <= tbl_mode_i;
				if (tbl_mode_i == `PMTAC_MODE_PREINC) begin
					pointer <= step(pointer, 1'b0);
				end
			end else if (tbl_pending) begin
				tbl_pending <= 1'b0;
				if (tbl_is_write) begin
					hold_write_o <= 1'b1;
					hold_index_o <= pointer[2:0];
					hold_data_o <= latch;
				end else begin
					mem_read_o <= 1'b1;
					mem_addr_o <= pointer;
				end
				case (tbl_mode_q)
					`PMTAC_MODE_POSTINC: begin
						pointer <= step(pointer, 1'b0);
					end
					`PMTAC_MODE_POSTDEC: begin
						pointer <= step(pointer, 1'b1);
					end
					default: begin
						pointer <= pointer;
					end
				endcase
			end
			if (mem_read_o) begin
				latch <= mem_rdata_i;
			end
		end
	end

	// ****************************************************************
	// register read mux
	// ****************************************************************
	always @* begin
		sfr_rdata_o = 8'h00; // unlock port and unmapped read zero
		if (sfr_read_i) begin
			if (hit(sfr_addr_i, `PMTAC_ADDR_CTRL)) begin
				sfr_rdata_o = ctrl_value;
			end else if (hit(sfr_addr_i, `PMTAC_ADDR_LATCH)) begin
				sfr_rdata_o = latch;
			end else if (hit(sfr_addr_i, `PMTAC_ADDR_PTR_LOW)) begin
				sfr_rdata_o = pointer[7:0];
			end else if (hit(sfr_addr_i, `PMTAC_ADDR_PTR_HIGH)) begin
				sfr_rdata_o = pointer[15:8];
			end else if (hit(sfr_addr_i, `PMTAC_ADDR_PTR_UPPER)) begin
				sfr_rdata_o = {2'h0, pointer[21:16]};
			end
		end
	end
endmodule // pmtac_ctrl
`default_nettype wire

// [logic/pmtac_defs.vh]
// register offsets, bit positions and timing constants for the table access control
`ifndef PMTAC_DEFS_VH
`define PMTAC_DEFS_VH
`define PMTAC_ADDR_CTRL 12'hfa6
`define PMTAC_ADDR_UNLOCK 12'hfa7
`define PMTAC_ADDR_LATCH 12'hff5
`define PMTAC_ADDR_PTR_LOW 12'hff6
`define PMTAC_ADDR_PTR_HIGH 12'hff7
`define PMTAC_ADDR_PTR_UPPER 12'hff8
`define PMTAC_BIT_TARGET 7
`define PMTAC_BIT_CFGSEL 6
`define PMTAC_BIT_UNUSED 5
`define PMTAC_BIT_ERASE 4
`define PMTAC_BIT_ERROR 3
`define PMTAC_BIT_WRITE_ENABLE_BIT 2
`define PMTAC_BIT_WSTROBE 1
`define PMTAC_BIT_RSTROBE 0
`define PMTAC_KEY_FIRST 8'h55
`define PMTAC_KEY_SECOND 8'haa
`define PMTAC_PTR_W 22
`define PMTAC_PTR_LOW_W 21
`define PMTAC_MODE_KEEP 2'h0
`define PMTAC_MODE_POSTINC 2'h1
`define PMTAC_MODE_POSTDEC 2'h2
`define PMTAC_MODE_PREINC 2'h3
`define PMTAC_LONG_WRITE_US 2000
`define PMTAC_CLK_MHZ 40
`define PMTAC_TIMER_W 20
`define PMTAC_EE_WRITE_CYCLES 20'h00010
`endif

// [logic/pmtac_write_timer.v]
// self-timed write and erase duration counter
`default_nettype none
module pmtac_write_timer #(
	parameter [19:0] LONG_CYCLES = 20'd80000
) (
	input wire clk_i,
	input wire reset_i,
	input wire start_i,
	input wire [19:0] length_i,
	output wire busy_o,
	output reg done_o
);
	reg [19:0] count;
	assign busy_o = (count != 20'h00000);
	// load on start, count down, pulse done on the final count
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count <= 20'h00000;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				count <= length_i;
			end else if (busy_o) begin
				count <= count - 20'h00001;
				if (count == 20'h00001) begin
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule // pmtac_write_timer
`default_nettype wire

// [verification/pmtac_ctrl_test.sv]
// self-checking bench for the table access control
`include "pmtac_defs.vh"
`default_nettype none
module pmtac_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, reset_i = 1, abort_reset_i = 0, sfr_write_i = 0, sfr_read_i = 0, tbl_read_i = 0, tbl_write_i = 0;
	logic [11:0] sfr_addr_i = 0;
	logic [7:0] sfr_wdata_i = 0, sfr_rdata_o, mem_rdata_i, hold_data_o, rd, lv, hd;
	logic [1:0] tbl_mode_i = 0, nv_space_o, sp;
	logic [21:0] mem_addr_o, p, a, got;
	logic [18:0] nv_block_o, blk;
	logic [2:0] hold_index_o, hx;
	logic tbl_busy_o, mem_read_o, hold_write_o, nv_start_o, nv_erase_o, ee_read_o, cpu_stall_o, nv_write_done_o, er, seen;
	logic [7:0] cv [5] = '{8'h04, 8'h84, 8'h94, 8'h44, 8'hc4};
	int n_errors = 0, n_tests = 0, starts = 0, dones = 0, eers = 0, k;
	pmtac_ctrl #(.LONG_WRITE_CYCLES(20'd20)) pmtac_ctrl_i (.clk_i(clk_i), .reset_i(reset_i),
		.abort_reset_i(abort_reset_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_write_i(sfr_write_i),
		.sfr_read_i(sfr_read_i), .sfr_rdata_o(sfr_rdata_o), .tbl_read_i(tbl_read_i), .tbl_write_i(tbl_write_i),
		.tbl_mode_i(tbl_mode_i), .tbl_busy_o(tbl_busy_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
		.mem_read_o(mem_read_o), .hold_write_o(hold_write_o), .hold_index_o(hold_index_o), .hold_data_o(hold_data_o),
		.nv_start_o(nv_start_o), .nv_erase_o(nv_erase_o), .nv_space_o(nv_space_o), .nv_block_o(nv_block_o),
		.ee_read_o(ee_read_o), .cpu_stall_o(cpu_stall_o), .nv_write_done_o(nv_write_done_o));
	pmtac_mem_model pmtac_mem_model_i (.clk_i(clk_i), .mem_read_i(mem_read_o), .mem_addr_i(mem_addr_o),
		.mem_rdata_o(mem_rdata_i));
	// ****
	// clock, event counters, helpers
	// ****
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// count starts, completions and eeprom reads
	always @(posedge clk_i) begin
		if (nv_start_o === 1'b1) begin
			starts++;
			sp = nv_space_o;
			er = nv_erase_o;
			blk = nv_block_o;
		end
		dones += int'(nv_write_done_o === 1'b1);
		eers += int'(ee_read_o === 1'b1);
	end
	function automatic logic [21:0] mv(input logic [21:0] q, input logic [20:0] d);
		return {q[21], q[20:0] + d};
	endfunction
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [11:0] ad, input logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = ad;
		sfr_wdata_i = d;
		sfr_write_i = 1;
		@(negedge clk_i);
		sfr_write_i = 0;
	endtask
	task automatic rdr(input logic [11:0] ad);
		@(negedge clk_i);
		sfr_addr_i = ad;
		sfr_read_i = 1;
		#1 rd = sfr_rdata_o;
		@(negedge clk_i);
		sfr_read_i = 0;
	endtask
	task automatic go(input logic [7:0] d);
		wr(`PMTAC_ADDR_UNLOCK, `PMTAC_KEY_FIRST);
		wr(`PMTAC_ADDR_UNLOCK, `PMTAC_KEY_SECOND);
		wr(`PMTAC_ADDR_CTRL, d);
	endtask
	task automatic setp(input logic [21:0] q);
		wr(`PMTAC_ADDR_PTR_LOW, q[7:0]);
		wr(`PMTAC_ADDR_PTR_HIGH, q[15:8]);
		wr(`PMTAC_ADDR_PTR_UPPER, {2'h0, q[21:16]});
	endtask
	task automatic rdptr();
		rdr(`PMTAC_ADDR_PTR_LOW);
		got[7:0] = rd;
		rdr(`PMTAC_ADDR_PTR_HIGH);
		got[15:8] = rd;
		rdr(`PMTAC_ADDR_PTR_UPPER);
		got[21:16] = rd[5:0];
	endtask
	task automatic tbl(input logic w, input logic [1:0] m);
		@(negedge clk_i);
		tbl_read_i = !w;
		tbl_write_i = w;
		tbl_mode_i = m;
		@(negedge clk_i);
		tbl_read_i = 0;
		tbl_write_i = 0;
		@(posedge clk_i);
		#1 seen = w ? hold_write_o : mem_read_o;
		a = mem_addr_o;
		hx = hold_index_o;
		hd = hold_data_o;
		@(posedge clk_i);
	endtask
	task automatic waitdone(input int n);
		for (k = 0; k < 200 && dones < n; k++) @(posedge clk_i);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#(25 * 20000);
		n_errors++;
		tally_and_finish();
	end
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(98));
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		reset_i = 0;
		rdr(`PMTAC_ADDR_CTRL);
		chk((rd & 8'h27) === 8'h00, "control reset value");
		wr(`PMTAC_ADDR_UNLOCK, 8'h55);
		rdr(`PMTAC_ADDR_UNLOCK);
		chk(rd === 8'h00, "unlock read");
		wr(`PMTAC_ADDR_CTRL, 8'h86);
		wr(`PMTAC_ADDR_CTRL, 8'h86);
		wr(`PMTAC_ADDR_CTRL, 8'h80);
		go(8'h82);
		rdr(`PMTAC_ADDR_CTRL);
		chk(rd[1] === 1'b0 && rd[5] === 1'b0 && starts == 0, "refused strobe");
		for (int i = 0; i < 5; i++) begin
			p = 22'($urandom);
			setp(p);
			wr(`PMTAC_ADDR_CTRL, cv[i]);
			go(cv[i] | 8'h02);
			wr(`PMTAC_ADDR_CTRL, cv[i]);
			rdr(`PMTAC_ADDR_CTRL);
			chk(rd[1] === 1'b1, "strobe cleared early");
			chk(cpu_stall_o === (cv[i][7] | cv[i][6]), "stall during write");
			waitdone(i + 1);
			chk(dones == i + 1 && starts == i + 1, "write not done");
			chk(sp === (cv[i][6] ? 2'h2 : {1'b0, cv[i][7]}) && er === cv[i][4], "target");
			chk(blk === (cv[i][4] ? {p[21:6], 3'h0} : p[21:3]), "block");
			rdr(`PMTAC_ADDR_CTRL);
			chk(rd[4:1] === 4'h2, "control after write");
		end
		go(8'hc6);
		repeat (3) @(negedge clk_i);
		abort_reset_i = 1;
		repeat (6) @(negedge clk_i);
		abort_reset_i = 0;
		rdr(`PMTAC_ADDR_CTRL);
		chk(rd[3] === 1'b1 && rd[7:6] === 2'h3, "abort flag");
		for (k = 0; k < 200 && cpu_stall_o !== 1'b0; k++) @(posedge clk_i);
		wr(`PMTAC_ADDR_CTRL, 8'h01);
		wr(`PMTAC_ADDR_CTRL, 8'h81);
		repeat (2) @(negedge clk_i);
		rdr(`PMTAC_ADDR_CTRL);
		chk(eers == 1 && rd[0] === 1'b0, "eeprom read strobe");
		for (int i = 0; i < 8; i++) begin
			p = 22'($urandom);
			if (i < 4) p = {1'b1, (i == 2) ? 21'h0 : 21'h1fffff};
			setp(p);
			lv = 8'($urandom);
			wr(`PMTAC_ADDR_LATCH, lv);
			tbl(i[2], i[1:0]);
			if (i[2]) chk(seen === 1'b1 && hx === p[2:0] + 3'(i == 7) && hd === lv, "hold write");
			else chk(seen === 1'b1 && a === ((i == 3) ? mv(p, 1) : p), "read address");
			rdr(`PMTAC_ADDR_LATCH);
			if (!i[2]) chk(rd === (a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]}), "latch data");
			rdptr();
			chk(got === (i[1:0] == 0 ? p : mv(p, i[1:0] == 2 ? 21'h1fffff : 21'h1)), "pointer");
		end
		tally_and_finish();
	end
endmodule // pmtac_ctrl_test
`default_nettype wire

// [verification/pmtac_mem_model.sv]
// program memory model answering table reads
`default_nettype none
module pmtac_mem_model (
	input wire logic clk_i,
	input wire logic mem_read_i,
	input wire logic [21:0] mem_addr_i,
	output logic [7:0] mem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic held = 1'b0;
	logic [7:0] junk = 8'h5a;
	// data valid for the request cycle and one after, churning otherwise
	always @(posedge clk_i) begin
		held <= mem_read_i;
		junk <= ~junk;
	end
	assign mem_rdata_o = (mem_read_i || held) ? mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ {2'h0, mem_addr_i[21:16]} : junk;
endmodule // pmtac_mem_model
`default_nettype wire

// [verification/pmtac_monitor.sv]
// port-level checks for the table access control
`include "pmtac_defs.vh"
`default_nettype none
module pmtac_monitor (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [11:0] sfr_addr_i,
	input wire logic sfr_read_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic tbl_read_i,
	input wire logic tbl_write_i,
	input wire logic tbl_busy_o,
	input wire logic cpu_stall_o,
	input wire logic mem_read_o,
	input wire logic hold_write_o,
	input wire logic nv_start_o,
	input wire logic nv_erase_o,
	input wire logic [1:0] nv_space_o,
	input wire logic [18:0] nv_block_o,
	input wire logic nv_write_done_o,
	input wire logic ee_read_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// ****
	// table requests
	// ****
	sequence rd_req; tbl_read_i && !tbl_busy_o && !cpu_stall_o; endsequence
	sequence wr_req; tbl_write_i && !tbl_busy_o && !cpu_stall_o; endsequence
	// register reads, table issue, write start and pulses
	unlock_reads_zero_a: assert property (sfr_read_i && sfr_addr_i == `PMTAC_ADDR_UNLOCK |-> sfr_rdata_o == 8'h00)
		else $error("unlock port read nonzero");
	spare_bit_zero_a: assert property (sfr_read_i && sfr_addr_i == `PMTAC_ADDR_CTRL |-> !sfr_rdata_o[5])
		else $error("spare bit reads one");
	table_read_issue_a: assert property (rd_req |-> ##2 mem_read_o)
		else $error("table read not issued");
	table_write_issue_a: assert property (wr_req |-> ##2 hold_write_o)
		else $error("table write not issued");
	erase_block_align_a: assert property (nv_start_o && nv_erase_o |-> nv_block_o[2:0] == 3'h0)
		else $error("erase block not aligned");
	long_write_stall_a: assert property (nv_start_o && nv_space_o != 2'h0 |-> cpu_stall_o)
		else $error("no stall on long write");
	done_pulse_a: assert property (nv_write_done_o |=> !nv_write_done_o)
		else $error("done flag not a pulse");
	ee_read_pulse_a: assert property (ee_read_o |=> !ee_read_o)
		else $error("eeprom read not a pulse");
endmodule // pmtac_monitor
bind pmtac_ctrl pmtac_monitor pmtac_monitor_i (.clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
	.sfr_read_i(sfr_read_i), .sfr_rdata_o(sfr_rdata_o), .tbl_read_i(tbl_read_i), .tbl_write_i(tbl_write_i),
	.tbl_busy_o(tbl_busy_o), .cpu_stall_o(cpu_stall_o), .mem_read_o(mem_read_o), .hold_write_o(hold_write_o),
	.nv_start_o(nv_start_o), .nv_erase_o(nv_erase_o), .nv_space_o(nv_space_o), .nv_block_o(nv_block_o),
	.nv_write_done_o(nv_write_done_o), .ee_read_o(ee_read_o));
`default_nettype wire
